// file: inc/aphi_defs.svh
`ifndef APHI_DEFS_SVH
`define APHI_DEFS_SVH

// Result word layout
`define APHI_RES_W          16
`define APHI_RES_MSB        15
`define APHI_RES_LSB        0
`define APHI_BYTE_W         8
`define APHI_RESET_RESULT   16'h0000

// Timing
`define APHI_CLK_HZ         25000000
`define APHI_CLK_NS         40
`define APHI_CONV_MAX_NS    2000
`define APHI_MIN_PULSE_NS   40

// FIFO geometry
`define APHI_FIFO_DEPTH     8

`endif

// file: inc/aphi_pkg.sv
package aphi_pkg;

   typedef logic [15:0] aphi_word_t;

   // Host control pins after synchronisation
   typedef struct packed {
      logic cs_n;
      logic rc_n;
      logic half_sel;
   } aphi_ctl_t;

   // Parallel bus drive: data and per-line output enable
   typedef struct packed {
      logic [15:0] data;
      logic [15:0] oe;
   } aphi_bus_t;

   typedef enum logic [1:0] {
      APHI_IDLE,
      APHI_CONV,
      APHI_LOAD
   } aphi_state_t;

endpackage

// file: logic/aphi_fifo.sv
`timescale 1ns/1ps
`include "aphi_defs.svh"

module aphi_fifo
   import aphi_pkg::*;
#(
   parameter int WIDTH = `APHI_RES_W,
   parameter int DEPTH = `APHI_FIFO_DEPTH
) (
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   input  wire logic [WIDTH-1:0] i_data,
   input  wire logic             i_valid,
   output logic                  o_ready,
   output logic      [WIDTH-1:0] o_data,
   output logic                  o_valid,
   input  wire logic             i_ready
);
   localparam int AW = $clog2(DEPTH);

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin
         $error("aphi_fifo: DEPTH must be a power of two, at least 2");
      end
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wp_r;
   logic [AW:0]      wp_nxt;
   logic [AW:0]      rp_r;
   logic [AW:0]      rp_nxt;
   logic             push;
   logic             pop;
   logic             full;
   logic             empty;

   always_comb begin
      full    = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
      empty   = (wp_r == rp_r);
      o_ready = !full;
      o_valid = !empty;
      o_data  = mem[rp_r[AW-1:0]];
      push    = i_valid && !full;
      pop     = i_ready && !empty;
      wp_nxt  = push ? wp_r + 1'b1 : wp_r;
      rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
      end
   end

   // Storage has no reset; contents are only read once written
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wp_r[AW-1:0]] <= i_data;
      end
   end

endmodule

// file: logic/aphi_host_if.sv
`timescale 1ns/1ps
`include "aphi_defs.svh"

// What this block and its host do
// RULE_01: busy_n low from conversion start until result register holds new word.
// RULE_02: half_select low shows upper byte, high shows lower byte.
// RULE_03: Chip select and read_convert are ORed; select fall with rc low starts.
// RULE_04: read_convert fall starts conversion when select low and busy_n high.
// RULE_05: read_convert rising with select low enables parallel outputs.
// RULE_06: Outputs high impedance whenever select high or read_convert low.
// RULE_07: Result MSB on line 15, LSB on line 0, descending between.
// RULE_08: Result is a 16-bit two's complement parallel word.
// RULE_09: Host holds start combination low at least 40 ns.
// RULE_10: Host keeps select or read_convert high as busy_n rises.
// RULE_11: Host may toggle half_select to read both bytes per conversion.
// RULE_12: Old result held during conversion; all 16 bits replaced at completion.

module aphi_host_if
   import aphi_pkg::*;
#(
   parameter int CONV_CYCLES = `APHI_CONV_MAX_NS / `APHI_CLK_NS
) (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_chip_select_n,
   input  wire logic        i_read_convert_n,
   input  wire logic        i_half_select,
   input  wire logic        i_byte_mode,
   input  wire logic [15:0] i_sample,
   input  wire logic        i_sample_valid,
   output logic             o_sample_ready,
   output logic             o_busy_n,
   output logic             o_sample_req,
   output logic [15:0]      o_data,
   output logic [15:0]      o_data_oe
);
   // ------------------------------------------------------------
   // Elaboration checks and timing
   // ------------------------------------------------------------
   localparam int MIN_PULSE_CYC =
      (`APHI_MIN_PULSE_NS + `APHI_CLK_NS - 1) / `APHI_CLK_NS;
   localparam int CW = $clog2(CONV_CYCLES + 1);

   initial begin
      if (CONV_CYCLES < 4) begin
         $error("aphi_host_if: CONV_CYCLES must be at least 4");
      end
      if (MIN_PULSE_CYC > 1) begin
         $error("aphi_host_if: clock too slow to catch a minimum convert pulse");
      end
   end

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   aphi_ctl_t meta_r;
   aphi_ctl_t sync_r;
   aphi_ctl_t prev_r;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         meta_r <= '{cs_n: 1'b1, rc_n: 1'b1, half_sel: 1'b0};
         sync_r <= '{cs_n: 1'b1, rc_n: 1'b1, half_sel: 1'b0};
         prev_r <= '{cs_n: 1'b1, rc_n: 1'b1, half_sel: 1'b0};
      end else begin
         meta_r <= '{cs_n: i_chip_select_n, rc_n: i_read_convert_n,
                     half_sel: i_half_select};
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   logic start_comb_now;
   logic start_comb_prev;
   logic start_evt;
   logic out_active;

   always_comb begin
      start_comb_now  = !(sync_r.cs_n | sync_r.rc_n);    // RULE_03
      start_comb_prev = !(prev_r.cs_n | prev_r.rc_n);
      // Falling edge of the ORed pair: a fall on either pin while the other is low
      start_evt       = start_comb_now && !start_comb_prev; // RULE_03 RULE_04
      out_active      = !sync_r.cs_n && sync_r.rc_n;       // RULE_05 RULE_06
   end

   // ------------------------------------------------------------
   // Conversion sequencer
   // ------------------------------------------------------------
   aphi_state_t      st_r;
   aphi_state_t      st_nxt;
   logic [CW-1:0]    cnt_r;
   logic [CW-1:0]    cnt_nxt;
   logic             busy_n_r;
   logic             busy_n_nxt;
   logic             req_r;
   logic             req_nxt;
   aphi_word_t       result_r;
   aphi_word_t       result_nxt;
   logic             fifo_ready;
   logic             fifo_valid;
   aphi_word_t       fifo_data;
   logic             fifo_pop;

   // Incoming samples are buffered so the converter core may run ahead
   aphi_fifo #(
      .WIDTH (`APHI_RES_W),
      .DEPTH (`APHI_FIFO_DEPTH)
   ) u_fifo (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_data  (i_sample),
      .i_valid (i_sample_valid),
      .o_ready (fifo_ready),
      .o_data  (fifo_data),
      .o_valid (fifo_valid),
      .i_ready (fifo_pop)
   );

   always_comb begin
      st_nxt     = st_r;
      cnt_nxt    = cnt_r;
      busy_n_nxt = busy_n_r;
      req_nxt    = 1'b0;
      result_nxt = result_r;
      fifo_pop   = 1'b0;
      unique case (st_r)
         APHI_IDLE: begin
            // Starts while busy are ignored
            if (start_evt && busy_n_r) begin          // RULE_04
               st_nxt     = APHI_CONV;
               cnt_nxt    = CW'(CONV_CYCLES - 2);
               busy_n_nxt = 1'b0;                     // RULE_01
               req_nxt    = 1'b1;
            end
         end
         APHI_CONV: begin
            if (cnt_r != '0) begin
               cnt_nxt = cnt_r - 1'b1;
            end else begin
               st_nxt = APHI_LOAD;
            end
         end
         APHI_LOAD: begin
            // Wait for a sample; busy_n stays low until the word is loaded
            if (fifo_valid) begin
               fifo_pop   = 1'b1;
               result_nxt = fifo_data;                // RULE_08 RULE_12
               busy_n_nxt = 1'b1;                     // RULE_01
               st_nxt     = APHI_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_r     <= APHI_IDLE;
         cnt_r    <= '0;
         busy_n_r <= 1'b1;
         req_r    <= 1'b0;
         result_r <= `APHI_RESET_RESULT;
      end else begin
         st_r     <= st_nxt;
         cnt_r    <= cnt_nxt;
         busy_n_r <= busy_n_nxt;
         req_r    <= req_nxt;
         result_r <= result_nxt;
      end
   end

   // ------------------------------------------------------------
   // Output bus drive
   // ------------------------------------------------------------
   aphi_bus_t bus_r;
   aphi_bus_t bus_nxt;
   logic      rdy_r;

   always_comb begin
      bus_nxt.data = '0;
      bus_nxt.oe   = '0;
      if (out_active) begin                            // RULE_05 RULE_06
         if (i_byte_mode) begin
            // Byte mode drives the low lane only
            bus_nxt.data[`APHI_BYTE_W-1:0] = sync_r.half_sel ?
               result_r[`APHI_BYTE_W-1:0] :
               result_r[`APHI_RES_MSB -: `APHI_BYTE_W];  // RULE_02
            bus_nxt.oe[`APHI_BYTE_W-1:0]   = '1;
         end else begin
            bus_nxt.data = result_r;                   // RULE_07
            bus_nxt.oe   = '1;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         bus_r <= '0;
         rdy_r <= 1'b0;
      end else begin
         bus_r <= bus_nxt;
         rdy_r <= fifo_ready;
      end
   end

   always_comb begin
      o_data         = bus_r.data;
      o_data_oe      = bus_r.oe;
      o_busy_n       = busy_n_r;
      o_sample_req   = req_r;
      o_sample_ready = rdy_r;
   end

endmodule

// file: testbench/aphi_chk_assertions.sv
`timescale 1ns/1ps
module aphi_chk
   import aphi_pkg::*;
#(
   parameter int CONV_CYCLES = 4
) (
   input wire logic        i_clk,
   input wire logic        i_rst,
   input wire logic        i_chip_select_n,
   input wire logic        i_read_convert_n,
   input wire logic        i_byte_mode,
   input wire logic        o_busy_n,
   input wire logic        o_sample_req,
   input wire logic [15:0] o_data,
   input wire logic [15:0] o_data_oe
);
   // Pins pass two sync stages and a register, so three quiet samples are needed; the checks wait four
   localparam int BMAX = CONV_CYCLES + 30;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   property p_hiz_cs;
      i_chip_select_n[*4] |=> o_data_oe == 16'h0000;
   endproperty
   property p_hiz_rc;
      !i_read_convert_n[*4] |=> o_data_oe == 16'h0000;
   endproperty
   property p_word;
      (!i_chip_select_n && i_read_convert_n && !i_byte_mode)[*4] |=> o_data_oe == 16'hFFFF;
   endproperty
   property p_byte;
      (!i_chip_select_n && i_read_convert_n && i_byte_mode)[*4] |=> o_data_oe == 16'h00FF;
   endproperty
   property p_req;
      o_sample_req |-> $fell(o_busy_n);
   endproperty
   property p_min;
      $fell(o_busy_n) |-> !o_busy_n[*8];
   endproperty
   property p_max;
      $fell(o_busy_n) |-> ##[1:BMAX] o_busy_n;
   endproperty
   property p_hold;
      !o_busy_n && !i_byte_mode && $stable(o_data_oe) |-> $stable(o_data);
   endproperty
   a_hiz_cs: assert property (p_hiz_cs) else $error("bus driven while deselected");
   a_hiz_rc: assert property (p_hiz_rc) else $error("bus driven in convert");
   a_word: assert property (p_word) else $error("word enable wrong");
   a_byte: assert property (p_byte) else $error("byte enable wrong");
   a_req: assert property (p_req) else $error("start pulse without busy");
   a_min: assert property (p_min) else $error("busy too short");
   a_max: assert property (p_max) else $error("busy never ends");
   a_hold: assert property (p_hold) else $error("result moved in conversion");
   c_start: cover property ($fell(o_busy_n));
   c_word: cover property (o_data_oe == 16'hFFFF);
   c_byte: cover property (o_data_oe == 16'h00FF);
endmodule

bind aphi_host_if aphi_chk #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
   .i_clk(i_clk), .i_rst(i_rst), .i_chip_select_n(i_chip_select_n),
   .i_read_convert_n(i_read_convert_n), .i_byte_mode(i_byte_mode), .o_busy_n(o_busy_n),
   .o_sample_req(o_sample_req), .o_data(o_data), .o_data_oe(o_data_oe));

// file: testbench/aphi_host_model.sv
`timescale 1ns/1ps
module aphi_host_model (
   input  wire logic i_clk,
   output logic      o_cs_n,
   output logic      o_rc_n,
   output logic      o_hs
);
   initial begin
      o_cs_n = 1'b1;
      o_rc_n = 1'b1;
      o_hs = 1'b0;
   end
   // The non-starting pin goes low a cycle early so the start source is clear
   task automatic start(input bit by_cs);
      @(posedge i_clk);
      if (by_cs) o_rc_n <= 1'b0;
      else o_cs_n <= 1'b0;
      @(posedge i_clk);
      if (by_cs) o_cs_n <= 1'b0;
      else o_rc_n <= 1'b0;
      repeat (3) @(posedge i_clk);
      o_cs_n <= 1'b1;
      o_rc_n <= 1'b1;
   endtask
   task automatic rd(input logic hs);
      @(posedge i_clk);
      o_hs <= hs;
      o_cs_n <= 1'b0;
      repeat (6) @(posedge i_clk);
      o_cs_n <= 1'b1;
      repeat (5) @(posedge i_clk);
   endtask
endmodule

// file: testbench/tb.sv
`timescale 1ns/1ps
`include "aphi_defs.svh"
module tb;
   import aphi_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic byte_m = 1'b0;
   logic s_valid = 1'b0;
   aphi_word_t s_data = 16'h0000;
   logic cs_n, rc_n, hs, sready, busy_n, req;
   logic [15:0] data, oe, lf, prev_oe;
   aphi_word_t wq[$];
   logic [31:0] eq[$];
   int err_count = 0;
   int checks = 0;
   int cyc = 0;
   int nreq = 0;
   always #20 i_clk = ~i_clk;
   aphi_host_model u_host (.i_clk(i_clk), .o_cs_n(cs_n), .o_rc_n(rc_n), .o_hs(hs));
   aphi_host_if #(.CONV_CYCLES(12)) u_dut (
      .i_clk(i_clk), .i_rst(i_rst), .i_chip_select_n(cs_n), .i_read_convert_n(rc_n),
      .i_half_select(hs), .i_byte_mode(byte_m), .i_sample(s_data), .i_sample_valid(s_valid),
      .o_sample_ready(sready), .o_busy_n(busy_n), .o_sample_req(req), .o_data(data),
      .o_data_oe(oe));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic finish_test;
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   function automatic logic [15:0] lfsr_next(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic push;
      lf = lfsr_next(lf);
      @(posedge i_clk);
      s_data <= lf;
      s_valid <= 1'b1;
      wq.push_back(lf);
      @(posedge i_clk);
      s_valid <= 1'b0;
   endtask
   task automatic wait_busy(input logic v);
      int n;
      n = 0;
      while (busy_n !== v && n < 60) begin
         @(negedge i_clk);
         n++;
      end
      chk(32'(busy_n), 32'(v));
   endtask
   // ----
   // Read monitor: each new bus enable consumes the oldest expected read
   // ----
   always @(posedge i_clk) begin
      if (oe !== 16'h0000 && prev_oe === 16'h0000 && eq.size() > 0) begin
         chk({data, oe}, eq.pop_front());
      end
      prev_oe <= oe;
      if (req === 1'b1) nreq++;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         finish_test();
      end
   end
   initial begin
      aphi_word_t exp;
      aphi_word_t prev_w;
      prev_w = `APHI_RESET_RESULT;
      lf = 16'hBE03;
      prev_oe = 16'h0000;
      repeat (16) @(posedge i_clk);
      i_rst <= 1'b0;
      // Fill the buffer with no conversions running, until it refuses
      for (int k = 0; k < 12; k++) begin
         @(posedge i_clk);
         @(negedge i_clk);
         if (sready) push();
      end
      chk(wq.size(), `APHI_FIFO_DEPTH);
      chk(32'(sready), 32'(1'b0));
      for (int i = 0; i < 8; i++) begin
         byte_m <= i[2];
         u_host.start(i[0]);
         wait_busy(1'b0);
         @(negedge i_clk);
         if (sready) push();
         // A second start while busy must leave no trace; its select-first
         // lead-in briefly reads the bus, which must still show the old word
         if (byte_m) begin
            eq.push_back({8'h00, hs ? prev_w[7:0] : prev_w[15:8], 16'h00FF});
         end else begin
            eq.push_back({prev_w, 16'hFFFF});
         end
         u_host.start(1'b0);
         wait_busy(1'b1);
         exp = wq.pop_front();
         if (byte_m) begin
            eq.push_back({8'h00, exp[15:8], 16'h00FF});
            u_host.rd(1'b0);
            eq.push_back({8'h00, exp[7:0], 16'h00FF});
            u_host.rd(1'b1);
         end else begin
            eq.push_back({exp, 16'hFFFF});
            u_host.rd(1'b0);
         end
         prev_w = exp;
      end
      chk(nreq, 8);
      chk(eq.size(), 0);
      finish_test();
   end
endmodule
